// ### logic/time_sync_regs.vh
// Register map, field positions and constants of the time-keeping register set
// Contract
// - On each pulse-per-second event capture nanoseconds plus two seconds bits into pulse snapshot.
// - On each cable master time arrival capture nanoseconds plus two seconds bits.
// - Master sends its seconds over cable at each whole-second crossing; value readable.
// - Any write to error clear register clears all latched cable errors; write only.
// - Report outgoing cable module-absent, loss of signal, loss of sync, error count.
// - Report incoming cable status in its own read-only register.
// - Keep a 64-bit tick counter read as upper and lower 32-bit halves.
// - Tick control offers local enable, cable select, clock select, no-reset, cable status.
// - Hold the seconds count in its own 32-bit software register.
// - Hold the nanoseconds count in a separate 32-bit software register.
`ifndef TIME_SYNC_REGS_VH
`define TIME_SYNC_REGS_VH
`define OFS_PPS_SNAP      16'h0200
`define OFS_CABLE_SNAP    16'h0210
`define OFS_ERR_CLEAR     16'h0400
`define OFS_OUT_STATUS    16'h0410
`define OFS_IN_STATUS     16'h0420
`define OFS_MASTER_SEC    16'h0430
`define OFS_IRQ_STATUS    16'h0440
`define OFS_IRQ_MASK      16'h0444
`define OFS_TICK_HIGH     16'h1000
`define OFS_TICK_LOW      16'h1008
`define OFS_TICK_CTRL     16'h1010
`define OFS_SECONDS       16'h1100
`define OFS_NANOS         16'h1108
`define CTRL_CABLE_CLK    0
`define CTRL_CABLE_EN     1
`define CTRL_LOCAL_EN     2
`define CTRL_NO_RESET     3
`define CTRL_CABLE_STAT   4
`define CTRL_RESET        4'h4
`define ST_ABSENT         31
`define ST_LOS            30
`define ST_RX_LOS         29
`define ST_RX_SYNC        28
`define ST_RX_LOCK        27
`define IRQ_PPS           0
`define IRQ_CABLE         1
`define IRQ_SECOND        2
`define NS_PER_SEC        32'h3B9ACA00
`define CLK_PERIOD_NS     32'h00000014
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10
`endif

// ### logic/pin_sync.v
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync
(
    input  wire core_clk,
    input  wire rst_n,
    input  wire pinIn,
    output reg  level,
    output reg  rise
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end
        else
        begin
            s1   <= pinIn;
            s2   <= s1;
            s3   <= s2;
            rise <= 1'b0;
            // Change counts only once stages two and three agree
            if (s2 == s3)
            begin
                level <= s3;
                rise  <= s3 & ~level;
            end
        end
    end
endmodule // pin_sync

// ### logic/cable_link.v
// Serial cable framing: sends master seconds, receives peer seconds
`timescale 1ns/1ps
module cable_link
(
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        sendReq,
    input  wire [31:0] sendWord,
    output reg         txData,
    output reg         txClk,
    input  wire        rxClkRise,
    input  wire        rxData,
    output reg         rxDone,
    output reg  [31:0] rxWord
);
    reg [31:0] txShift;
    reg [5:0]  txCnt;
    reg [2:0]  txDiv;
    reg [5:0]  rxCnt;
    reg [31:0] rxShift;
    // Frame: start bit of one then 32 data bits, MSB first
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txShift <= 32'h00000000;
            txCnt   <= 6'h00;
            txDiv   <= 3'h0;
            txData  <= 1'b0;
            txClk   <= 1'b0;
        end
        else
        begin
            txDiv <= txDiv + 3'h1;
            if (sendReq && txCnt == 6'h00)
            begin
                txShift <= sendWord;
                txCnt   <= 6'h21;
                txDiv   <= 3'h0;
            end
            else if (txCnt != 6'h00)
            begin
                if (txDiv == 3'h0)
                begin
                    txClk <= 1'b0;
                    if (txCnt == 6'h21)
                        txData <= 1'b1;
                    else
                    begin
                        txData  <= txShift[31];
                        txShift <= {txShift[30:0], 1'b0};
                    end
                end
                else if (txDiv == 3'h3)
                    txClk <= 1'b1;
                else if (txDiv == 3'h7)
                    txCnt <= txCnt - 6'h01;
            end
            else
            begin
                txClk  <= 1'b0;
                txData <= 1'b0;
            end
        end
    end
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxCnt   <= 6'h00;
            rxShift <= 32'h00000000;
            rxDone  <= 1'b0;
            rxWord  <= 32'h00000000;
        end
        else
        begin
            rxDone <= 1'b0;
            if (rxClkRise)
            begin
                if (rxCnt == 6'h00)
                begin
                    if (rxData)
                        rxCnt <= 6'h20;
                end
                else
                begin
                    rxShift <= {rxShift[30:0], rxData};
                    rxCnt   <= rxCnt - 6'h01;
                    if (rxCnt == 6'h01)
                    begin
                        rxDone <= 1'b1;
                        rxWord <= {rxShift[30:0], rxData};
                    end
                end
            end
        end
    end
endmodule // cable_link

// ### logic/time_sync_regs.v
// Tick clock, wall clock, snapshots and cable status behind AXI4-Lite
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "time_sync_regs.vh"
module time_sync_regs
(
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [15:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [15:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        ppsPin,
    input  wire        cableClkPin,
    input  wire        rxDataPin,
    input  wire        rxLinkPin,
    input  wire        outModAbsentPin,
    input  wire        outLosPin,
    input  wire        outRxLosPin,
    input  wire        outRxSyncLossPin,
    input  wire        inModAbsentPin,
    input  wire        inLosPin,
    input  wire        isMaster,
    output reg         txData,
    output reg         txClk,
    output reg         irq
);
    wire        ppsLvl;
    wire        ppsRise;
    wire        cclkLvl;
    wire        cclkRise;
    wire        rxDataLvl;
    wire        rxLinkLvl;
    wire        oAbs;
    wire        oLos;
    wire        oRxLos;
    wire        oSync;
    wire        iAbs;
    wire        iLos;
    wire        rxDone;
    wire [31:0] rxWord;
    wire        linkTxData;
    wire        linkTxClk;
    reg  [63:0] tick_q;
    reg  [31:0] sec_q;
    reg  [31:0] ns_q;
    reg  [31:0] tickHiHold_q;
    reg  [31:0] nsHold_q;
    reg  [3:0]  ctrl_q;
    reg  [31:0] ppsSnap_q;
    reg  [31:0] cableSnap_q;
    reg  [31:0] masterSec_q;
    reg  [7:0]  errCnt_q;
    reg  [4:0]  outErr_q;
    reg  [1:0]  inErr_q;
    reg  [2:0]  irqStat_q;
    reg  [2:0]  irqMask_q;
    reg         secWrap_q;
    reg  [15:0] wAddr_q;
    reg  [31:0] wData_q;
    reg  [3:0]  wStrb_q;
    reg         haveA_q;
    reg         haveW_q;
    reg         doWrite;
    reg  [2:0]  irqSet;

    // Synchronise every pin through the same three-stage filter
    pin_sync uPps  (.core_clk(core_clk), .rst_n(rst_n), .pinIn(ppsPin),
                    .level(ppsLvl), .rise(ppsRise));
    pin_sync uCclk (.core_clk(core_clk), .rst_n(rst_n), .pinIn(cableClkPin),
                    .level(cclkLvl), .rise(cclkRise));
    pin_sync uRxd  (.core_clk(core_clk), .rst_n(rst_n), .pinIn(rxDataPin),
                    .level(rxDataLvl), .rise());
    pin_sync uLink (.core_clk(core_clk), .rst_n(rst_n), .pinIn(rxLinkPin),
                    .level(rxLinkLvl), .rise());
    pin_sync uOAbs (.core_clk(core_clk), .rst_n(rst_n), .pinIn(outModAbsentPin),
                    .level(oAbs), .rise());
    pin_sync uOLos (.core_clk(core_clk), .rst_n(rst_n), .pinIn(outLosPin),
                    .level(oLos), .rise());
    pin_sync uORx  (.core_clk(core_clk), .rst_n(rst_n), .pinIn(outRxLosPin),
                    .level(oRxLos), .rise());
    pin_sync uOSyn (.core_clk(core_clk), .rst_n(rst_n), .pinIn(outRxSyncLossPin),
                    .level(oSync), .rise());
    pin_sync uIAbs (.core_clk(core_clk), .rst_n(rst_n), .pinIn(inModAbsentPin),
                    .level(iAbs), .rise());
    pin_sync uILos (.core_clk(core_clk), .rst_n(rst_n), .pinIn(inLosPin),
                    .level(iLos), .rise());

    cable_link uLinkIo
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .sendReq   (secWrap_q & isMaster),
        .sendWord  (sec_q),
        .txData    (linkTxData),
        .txClk     (linkTxClk),
        .rxClkRise (cclkRise),
        .rxData    (rxDataLvl),
        .rxDone    (rxDone),
        .rxWord    (rxWord)
    );

    function [31:0] merge;
        input [31:0] oldV;
        input [31:0] newV;
        input [3:0]  strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge[k*8 +: 8] = strb[k] ? newV[k*8 +: 8] : oldV[k*8 +: 8];
        end
    endfunction

    wire cableTickEn = ctrl_q[`CTRL_CABLE_EN] & rxLinkLvl;
    wire lockLoss = ctrl_q[`CTRL_CABLE_EN] & ~cclkLvl & ~rxLinkLvl;
    wire tickEn = ctrl_q[`CTRL_CABLE_EN] ? cableTickEn : ctrl_q[`CTRL_LOCAL_EN];
    wire tickStep = ctrl_q[`CTRL_CABLE_CLK] ? cclkRise : 1'b1;
    wire nsWrap = (ns_q + `CLK_PERIOD_NS) >= `NS_PER_SEC;

    always @*
    begin
        doWrite = haveA_q & haveW_q & ~s_axi_bvalid;
        irqSet = 3'b000;
        irqSet[`IRQ_PPS]    = ppsRise;
        irqSet[`IRQ_CABLE]  = rxDone;
        irqSet[`IRQ_SECOND] = secWrap_q;
    end

    // AXI write channel: address and data taken in either order
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            haveA_q       <= 1'b0;
            haveW_q       <= 1'b0;
            wAddr_q       <= 16'h0000;
            wData_q       <= 32'h00000000;
            wStrb_q       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                wAddr_q       <= s_axi_awaddr;
                haveA_q       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                haveW_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                haveA_q      <= 1'b0;
                haveW_q      <= 1'b0;
                case (wAddr_q)
                    `OFS_ERR_CLEAR, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_TICK_HIGH,
                    `OFS_TICK_LOW, `OFS_TICK_CTRL, `OFS_SECONDS, `OFS_NANOS:
                        s_axi_bresp <= `AXI_OKAY;
                    default:
                        s_axi_bresp <= `AXI_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Clocks, snapshots, errors and interrupt state
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_q      <= 64'h0000000000000000;
            sec_q       <= 32'h00000000;
            ns_q        <= 32'h00000000;
            ctrl_q      <= `CTRL_RESET;
            ppsSnap_q   <= 32'h00000000;
            cableSnap_q <= 32'h00000000;
            masterSec_q <= 32'h00000000;
            errCnt_q    <= 8'h00;
            outErr_q    <= 5'h00;
            inErr_q     <= 2'h0;
            irqStat_q   <= 3'h0;
            irqMask_q   <= 3'h0;
            secWrap_q   <= 1'b0;
            txData      <= 1'b0;
            txClk       <= 1'b0;
            irq         <= 1'b0;
        end
        else
        begin
            txData    <= linkTxData;
            txClk     <= linkTxClk;
            secWrap_q <= 1'b0;
            if (tickEn && tickStep)
                tick_q <= tick_q + 64'h0000000000000001;
            else if (!tickEn && !ctrl_q[`CTRL_NO_RESET])
                tick_q <= 64'h0000000000000000;
            if (nsWrap)
            begin
                ns_q      <= ns_q + `CLK_PERIOD_NS - `NS_PER_SEC;
                sec_q     <= sec_q + 32'h00000001;
                secWrap_q <= 1'b1;
            end
            else
                ns_q <= ns_q + `CLK_PERIOD_NS;
            if (ppsRise)
                ppsSnap_q <= {sec_q[1:0], ns_q[29:0]};
            if (rxDone)
            begin
                cableSnap_q <= {sec_q[1:0], ns_q[29:0]};
                masterSec_q <= rxWord;
            end
            if (secWrap_q && isMaster)
                masterSec_q <= sec_q;
            // Errors latch until cleared; a new error beats the clear
            if (doWrite && wAddr_q == `OFS_ERR_CLEAR)
            begin
                outErr_q <= {oAbs, oLos, oRxLos, oSync, lockLoss};
                inErr_q  <= {iAbs, iLos};
                errCnt_q <= {7'h00, oLos | oSync};
            end
            else
            begin
                outErr_q <= outErr_q | {oAbs, oLos, oRxLos, oSync, lockLoss};
                inErr_q  <= inErr_q | {iAbs, iLos};
                if ((oLos || oSync) && errCnt_q != 8'hFF)
                    errCnt_q <= errCnt_q + 8'h01;
            end
            irqStat_q <= irqStat_q | irqSet;
            if (doWrite)
            begin
                case (wAddr_q)
                    `OFS_TICK_HIGH:
                        tick_q[63:32] <= merge(tick_q[63:32], wData_q, wStrb_q);
                    `OFS_TICK_LOW:
                        tick_q[31:0] <= merge(tick_q[31:0], wData_q, wStrb_q);
                    `OFS_TICK_CTRL:
                        ctrl_q <= wStrb_q[0] ? wData_q[3:0] : ctrl_q;
                    `OFS_SECONDS:
                        sec_q <= merge(sec_q, wData_q, wStrb_q);
                    `OFS_NANOS:
                        ns_q <= merge(ns_q, wData_q, wStrb_q);
                    `OFS_IRQ_MASK:
                        irqMask_q <= wData_q[2:0];
                    `OFS_IRQ_STATUS:
                        irqStat_q <= (irqStat_q & ~wData_q[2:0]) | irqSet;
                    default:
                        irqMask_q <= irqMask_q;
                endcase
            end
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // AXI read channel; tick low read latches tick high, seconds read latches nanoseconds, for coherent reads
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_OKAY;
            tickHiHold_q  <= 32'h00000000;
            nsHold_q      <= 32'h00000000;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `AXI_OKAY;
                case (s_axi_araddr)
                    `OFS_PPS_SNAP:   s_axi_rdata <= ppsSnap_q;
                    `OFS_CABLE_SNAP: s_axi_rdata <= cableSnap_q;
                    `OFS_OUT_STATUS: s_axi_rdata <= {outErr_q, 19'h00000, errCnt_q};
                    `OFS_IN_STATUS:  s_axi_rdata <= {inErr_q, 30'h00000000};
                    `OFS_MASTER_SEC: s_axi_rdata <= masterSec_q;
                    `OFS_IRQ_STATUS: s_axi_rdata <= {29'h00000000, irqStat_q};
                    `OFS_IRQ_MASK:   s_axi_rdata <= {29'h00000000, irqMask_q};
                    `OFS_TICK_LOW:
                    begin
                        s_axi_rdata  <= tick_q[31:0];
                        tickHiHold_q <= tick_q[63:32];
                    end
                    `OFS_TICK_HIGH:  s_axi_rdata <= tickHiHold_q;
                    `OFS_TICK_CTRL:
                        s_axi_rdata <= {27'h0000000, cableTickEn, ctrl_q};
                    `OFS_SECONDS:
                    begin
                        s_axi_rdata <= sec_q;
                        nsHold_q    <= ns_q;
                    end
                    `OFS_NANOS:      s_axi_rdata <= nsHold_q;
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `AXI_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // time_sync_regs

// ### test/time_sync_regs_asserts.sv
// Checker of bus handshakes, refusals and cable bit timing
`timescale 1ns/1ps
module time_sync_regs_asserts
(
    input wire        core_clk,
    input wire        rst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        txClk
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence sRead;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence sWrite;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (sRead |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    a_write_answer: assert property (sWrite |-> ##[1:3] s_axi_bvalid)
        else $error("write answer missing");
    a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready stayed");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed");
    a_clear_unread: assert property (sRead ##0 s_axi_araddr == 16'h0400 |=>
        s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000)
        else $error("error clear was readable");
    a_hole_refused: assert property (sRead ##0 s_axi_araddr == 16'h0004 |=>
        s_axi_rresp == 2'b10)
        else $error("unmapped read accepted");
    a_bit_period: assert property ($rose(txClk) |=> !$rose(txClk) [*7])
        else $error("cable bit too short");
endmodule // time_sync_regs_asserts
bind time_sync_regs time_sync_regs_asserts i_chk (.*);

// ### test/cable_peer_model.sv
// Peer card model sending one framed seconds word over the cable
`timescale 1ns/1ps
module cable_peer_model
(
    input  wire        core_clk,
    input  wire        go,
    input  wire [31:0] word,
    output reg         cClk,
    output reg         cData
);
    reg [32:0] sh;
    integer    b;
    integer    k;
    initial
    begin
        cClk = 1'b0;
        cData = 1'b0;
        forever
        begin
            wait (go);
            sh = {1'b1, word};
            for (b = 0; b < 33; b = b + 1)
            begin
                cData <= #3 sh[32 - b]; // Start bit then MSB first
                for (k = 0; k < 8; k = k + 1)
                begin
                    @(posedge core_clk);
                    // Offset delay keeps the cable clock off core edges
                    cClk <= #7 (k >= 3) && (k < 7);
                end
            end
            // Released line must not keep showing the last bit
            cData <= #3 ~cData;
        end
    end
endmodule // cable_peer_model

// ### test/time_sync_regs_tb.sv
// Self-checking bench of the time-keeping register set
`timescale 1ns/1ps
`include "time_sync_regs.vh"
module time_sync_regs_tb;
    reg         core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, ppsPin, rxLinkPin, isMaster, go;
    reg         outModAbsentPin, outLosPin, outRxLosPin, outRxSyncLossPin;
    reg         inModAbsentPin, inLosPin, irqA;
    reg  [15:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, rdv, sec, w;
    reg  [3:0]  s_axi_wstrb;
    reg  [1:0]  rsp;
    reg  [32:0] txBits;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, txData, txClk, irq, cableClkPin, rxDataPin;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     seed, failures, total_checks, txN;
    always #10 core_clk = ~core_clk;
    time_sync_regs i_dut (.*);
    cable_peer_model i_peer (.core_clk(core_clk), .go(go), .word(w),
        .cClk(cableClkPin), .cData(rxDataPin));
    always @(posedge txClk)
    begin
        txBits = {txBits[31:0], txData};
        txN = txN + 1;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp)
            begin
                failures = failures + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task automatic wr(input [15:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge core_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            for (n = 0; n < 100; n = n + 1)
            begin
                @(posedge core_clk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid)
                begin
                    rsp = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    n = 200;
                end
            end
            if (n < 200)
                failures = failures + 1;
        end
    endtask
    task automatic rd(input [15:0] a);
        integer n;
        begin
            @(posedge core_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            for (n = 0; n < 100; n = n + 1)
            begin
                @(posedge core_clk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid)
                begin
                    rdv = s_axi_rdata;
                    rsp = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    n = 200;
                end
            end
            if (n < 200)
                failures = failures + 1;
        end
    endtask
    task end_of_test;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial
    begin
        #1000000;
        failures = failures + 1;
        end_of_test;
    end
    initial
    begin
        {core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, ppsPin, rxLinkPin, isMaster, go} = 6'h00;
        {outModAbsentPin, outLosPin, outRxLosPin, outRxSyncLossPin} = 4'h0;
        {inModAbsentPin, inLosPin, s_axi_awaddr, s_axi_araddr} = 34'h0;
        {s_axi_wdata, w, txBits} = 97'h0;
        s_axi_wstrb = 4'hF;
        {seed, failures, total_checks, txN} = {32'd64534, 96'h0};
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`OFS_TICK_CTRL);
        chk(rdv & 32'h0000000F, `CTRL_RESET);
        wr(`OFS_TICK_CTRL, 32'h0000001B);
        rd(`OFS_TICK_CTRL);
        chk(rdv & 32'h0000000F, 32'h0000000B);
        wr(`OFS_TICK_CTRL, 32'h00000004);
        $display("Test control done");
        w = $random(seed);
        wr(`OFS_TICK_HIGH, w);
        wr(`OFS_TICK_LOW, 32'h00000000);
        rd(`OFS_TICK_LOW);
        chk(rdv & 32'hFFFFFF00, 32'h00000000);
        rd(`OFS_TICK_HIGH);
        chk(rdv, w);
        $display("Test tick done");
        sec = $random(seed);
        wr(`OFS_SECONDS, sec);
        // Rollover lands about 20 cycles after the write
        wr(`OFS_NANOS, `NS_PER_SEC - 32'd400);
        repeat (40) @(posedge core_clk);
        sec = sec + 32'd1;
        rd(`OFS_SECONDS);
        chk(rdv, sec);
        rd(`OFS_NANOS);
        chk({31'h0, rdv < 32'd2000}, 32'h1);
        $display("Test wall clock done");
        wr(`OFS_NANOS, 32'h00000000);
        wr(`OFS_IRQ_STATUS, 32'h00000007);
        ppsPin <= 1'b1;
        repeat (3) @(posedge core_clk);
        ppsPin <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(`OFS_PPS_SNAP);
        chk(rdv[31:30], sec[1:0]);
        chk({31'h0, rdv[29:0] < 30'd2000}, 32'h1);
        rd(`OFS_IRQ_STATUS);
        chk(rdv & 32'h00000001, 32'h00000001);
        wr(`OFS_IRQ_MASK, 32'h00000000);
        repeat (3) @(posedge core_clk);
        irqA = irq;
        wr(`OFS_IRQ_MASK, 32'h00000007);
        repeat (3) @(posedge core_clk);
        chk(irqA ^ irq, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h00000001);
        rd(`OFS_IRQ_STATUS);
        chk(rdv & 32'h00000001, 32'h00000000);
        $display("Test pulse snapshot done");
        w = $random(seed);
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (300) @(posedge core_clk);
        rd(`OFS_MASTER_SEC);
        chk(rdv, w);
        rd(`OFS_CABLE_SNAP);
        chk(rdv[31:30], sec[1:0]);
        rd(`OFS_IRQ_STATUS);
        chk(rdv & 32'h00000002, 32'h00000002);
        $display("Test cable receive done");
        isMaster <= 1'b1;
        sec = $random(seed);
        wr(`OFS_SECONDS, sec);
        txN = 0;
        wr(`OFS_NANOS, `NS_PER_SEC - 32'd400);
        repeat (320) @(posedge core_clk);
        chk(txN, 33);
        chk(txBits[31:0], sec + 32'd1);
        chk(txBits[32], 1'b1);
        rd(`OFS_MASTER_SEC);
        chk(rdv, sec + 32'd1);
        $display("Test cable send done");
        {outModAbsentPin, outLosPin, outRxLosPin, outRxSyncLossPin} <= 4'hF;
        {inModAbsentPin, inLosPin} <= 2'h3;
        repeat (10) @(posedge core_clk);
        {outModAbsentPin, outLosPin, outRxLosPin, outRxSyncLossPin} <= 4'h0;
        repeat (10) @(posedge core_clk);
        rd(`OFS_OUT_STATUS);
        chk(rdv[31:28], 4'hF);
        chk({31'h0, rdv[7:0] != 8'h00}, 32'h1);
        rd(`OFS_IN_STATUS);
        chk(rdv[31:30], 2'h3);
        wr(`OFS_ERR_CLEAR, $random(seed));
        rd(`OFS_OUT_STATUS);
        chk(rdv & 32'hF80000FF, 32'h00000000);
        rd(`OFS_ERR_CLEAR);
        chk(rsp, `AXI_SLVERR);
        wr(16'h0004, 32'h00000000);
        chk(rsp, `AXI_SLVERR);
        rd(16'h0004);
        chk(rsp, `AXI_SLVERR);
        $display("Test cable errors done");
        end_of_test;
    end
endmodule // time_sync_regs_tb
